//--- pvc_caldiv.v
`include "pvc_map.vh"
`default_nettype none
// Divides the reference clock into a one-cycle calibration clock enable
module pvc_caldiv (
  // Clock and reset
  input  wire       clk_i,
  input  wire       rst_i,
  // Divider select
  input  wire [1:0] code_i,
  // Enable out
  output reg        tick_o
);
  reg [3:0] cnt_q;
  reg [3:0] last;

  // Terminal count per code; the ratio is the count plus one
  always @* begin
    case (code_i)
      2'h0:    last = 4'h1;
      2'h1:    last = 4'h3;
      2'h2:    last = 4'h7;
      default: last = 4'hf;
    endcase
  end

  // A new terminal at or below the count ends the period at once, never overshoots
  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q  <= 4'h0;
      tick_o <= 1'b0;
    end else if (cnt_q >= last) begin
      cnt_q  <= 4'h0;
      tick_o <= 1'b1;
    end else begin
      cnt_q  <= cnt_q + 4'h1;
      tick_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- pvc_map.vh
`ifndef PVC_MAP_VH
`define PVC_MAP_VH
// Register indices; the byte address is four times the index
`define PVC_IDX_SYNC_DLY     12'h019
`define PVC_IDX_CAL_CTRL     12'h018
`define PVC_IDX_TRANSFER     12'h232
`define PVC_ADDR_SYNC_DLY    14'h0064
`define PVC_ADDR_CAL_CTRL    14'h0060
`define PVC_ADDR_TRANSFER    14'h08c8
// Field positions
`define PVC_SYNC_MODE_HI     7
`define PVC_SYNC_MODE_LO     6
`define PVC_RDLY_HI          5
`define PVC_RDLY_LO          3
`define PVC_NDLY_HI          2
`define PVC_NDLY_LO          0
`define PVC_CALDIV_HI        2
`define PVC_CALDIV_LO        1
`define PVC_CALNOW_BIT       0
`define PVC_UPDATE_BIT       0
// Reset values
`define PVC_RST_SYNC_DLY     8'h00
`define PVC_RST_CAL_CTRL     8'h06
// Sync-reset modes
`define PVC_SYNC_NONE        2'h0
`define PVC_SYNC_ASYNC       2'h1
`define PVC_SYNC_SYNC        2'h2
`define PVC_SYNC_NONE2       2'h3
// Calibration length in calibration-clock ticks
`define PVC_CAL_TICKS        16'h0200
`endif

//--- pvc_sync_drv.sv
`default_nettype none
module pvc_sync_drv (
  input  wire logic clk_i,
  input  wire logic go_i,
  output var  logic sync_n_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Pin held low only while asked, high between pulses
  initial sync_n_o = 1'b1;
  always @(posedge clk_i) sync_n_o <= !go_i;
endmodule
`default_nettype wire

//--- pvc_top.v
// Functional notes
// - Calibration clock is the reference clock divided by the programmed ratio.
// - Divider code 00 divides by two, for PFD below 12.5 MHz.
// - Divider code 01 divides by four, for PFD below 25 MHz.
// - Divider code 10 divides by eight, for PFD below 50 MHz.
// - Code 11 divides by sixteen, reset default, slowest calibration.
// - Calibration starts only on a 0-to-1 change of active cal-now bit.
// - Written cal-now reaches active set only on update-all strobe bit 0.
// - Clearing cal-now discards the stored calibration result.
// - Sync mode field: 00 none, 01 async, 10 sync, 11 none.
// - Reference delay bits 5:3, feedback delay bits 2:0, reset zero.
`include "pvc_map.vh"
`default_nettype none
module pvc_top #(
  parameter [15:0] CAL_TICKS = `PVC_CAL_TICKS
) (
  // Clock and reset
  input  wire        CLK_I,
  input  wire        RST_I,
  // APB slave
  input  wire        PSEL_I,
  input  wire        PENABLE_I,
  input  wire        PWRITE_I,
  input  wire [13:0] PADDR_I,
  input  wire [31:0] PWDATA_I,
  output reg  [31:0] PRDATA_O,
  output reg         PREADY_O,
  output reg         PSLVERR_O,
  // Sync pin, active low
  input  wire        SYNC_N_I,
  // Counter control and path delays
  output reg         CNT_CLEAR_O,
  output reg  [2:0]  REF_DLY_O,
  output reg  [2:0]  FB_DLY_O,
  // Calibration status
  output reg         CAL_BUSY_O,
  output reg         CAL_VALID_O,
  output reg         CAL_TICK_O
);
  // Calibration states; DONE keeps the result until cal-now drops
  localparam [1:0] CAL_IDLE = 2'h0;
  localparam [1:0] CAL_RUN  = 2'h1;
  localparam [1:0] CAL_DONE = 2'h2;

  // Staged (written) and active register sets
  reg [7:0]  sync_dly_stg_q;
  reg [7:0]  sync_dly_stg_d;
  reg [7:0]  cal_ctrl_stg_q;
  reg [7:0]  cal_ctrl_stg_d;
  reg [7:0]  sync_dly_act_q;
  reg [7:0]  sync_dly_act_d;
  reg [7:0]  cal_ctrl_act_q;
  reg [7:0]  cal_ctrl_act_d;
  // Bus answer
  reg [31:0] prdata_d;
  // Calibration sequencer
  reg [1:0]  cal_st_q;
  reg [1:0]  cal_st_d;
  reg [15:0] cal_cnt_q;
  reg [15:0] cal_cnt_d;
  reg        calnow_prev_q;
  // Sync pin history for synchronous mode
  reg        sync_q;
  reg        clear_d;
  wire       cal_tick;

  wire acc   = PSEL_I & PENABLE_I & ~PREADY_O;
  wire wr    = acc & PWRITE_I;
  wire hit_s = (PADDR_I == `PVC_ADDR_SYNC_DLY);
  wire hit_c = (PADDR_I == `PVC_ADDR_CAL_CTRL);
  wire hit_t = (PADDR_I == `PVC_ADDR_TRANSFER);
  wire upd   = wr & hit_t & PWDATA_I[`PVC_UPDATE_BIT];
  wire [1:0] mode = sync_dly_act_q[`PVC_SYNC_MODE_HI:`PVC_SYNC_MODE_LO];
  wire calnow = cal_ctrl_act_q[`PVC_CALNOW_BIT];
  wire sync_act = ~SYNC_N_I;
  // Read access and cal-now edge
  wire rd_acc = acc & ~PWRITE_I;
  wire calnow_rise = calnow & ~calnow_prev_q;
  // Last count of a run; a parameter of 1 gives a one-tick run
  wire [15:0] cal_last = CAL_TICKS - 16'h0001;

  // Read mux; unmapped reads and all writes answer zero
  always @* begin
    prdata_d = 32'h0000_0000;
    // Bit 0 of cal control shows a held result, not the request
    if (rd_acc & hit_s)
      prdata_d = {24'h000000, sync_dly_stg_q};
    else if (rd_acc & hit_c)
      prdata_d = {24'h000000, cal_ctrl_stg_q[7:1], calnow & CAL_VALID_O};
  end

  // One wait state: answer in the cycle after the access phase starts
  always @(posedge CLK_I) begin
    if (RST_I) begin
      PREADY_O  <= 1'b0;
      PSLVERR_O <= 1'b0;
      PRDATA_O  <= 32'h0000_0000;
    end else begin
      // Ready lasts one cycle, so a held request is never taken twice
      PREADY_O  <= acc;
      // Unmapped offsets raise an error but leave every register alone
      PSLVERR_O <= acc & ~(hit_s | hit_c | hit_t);
      PRDATA_O  <= prdata_d;
    end
  end

  // Writes land in the staged set; nothing acts on them before update
  always @* begin
    sync_dly_stg_d = sync_dly_stg_q;
    cal_ctrl_stg_d = cal_ctrl_stg_q;
    sync_dly_act_d = sync_dly_act_q;
    cal_ctrl_act_d = cal_ctrl_act_q;
    if (wr & hit_s)
      sync_dly_stg_d = PWDATA_I[7:0];
    if (wr & hit_c)
      cal_ctrl_stg_d = PWDATA_I[7:0];
    // Whole-set copy, so fields of one register never go live apart
    if (upd) begin
      sync_dly_act_d = sync_dly_stg_q;
      cal_ctrl_act_d = cal_ctrl_stg_q;
    end
  end

  // Staged and active sets
  always @(posedge CLK_I) begin
    if (RST_I) begin
      sync_dly_stg_q <= `PVC_RST_SYNC_DLY;
      cal_ctrl_stg_q <= `PVC_RST_CAL_CTRL;
      sync_dly_act_q <= `PVC_RST_SYNC_DLY;
      cal_ctrl_act_q <= `PVC_RST_CAL_CTRL;
    end else begin
      sync_dly_stg_q <= sync_dly_stg_d;
      cal_ctrl_stg_q <= cal_ctrl_stg_d;
      sync_dly_act_q <= sync_dly_act_d;
      cal_ctrl_act_q <= cal_ctrl_act_d;
    end
  end

  // Calibration clock enable from the reference clock; a new code
  // landing mid-period stretches or shortens that one period only
  pvc_caldiv u_div (
    .clk_i  (CLK_I),
    .rst_i  (RST_I),
    .code_i (cal_ctrl_act_q[`PVC_CALDIV_HI:`PVC_CALDIV_LO]),
    .tick_o (cal_tick)
  );

  // Next state of the calibration run; cal-now low always wins
  always @* begin
    cal_st_d  = cal_st_q;
    cal_cnt_d = cal_cnt_q;
    if (!calnow) begin
      cal_st_d = CAL_IDLE;
    end else if (calnow_rise) begin
      cal_st_d  = CAL_RUN;
      cal_cnt_d = 16'h0000;
    end else begin
      case (cal_st_q)
        CAL_IDLE: cal_st_d = CAL_IDLE;
        CAL_RUN: begin
          // Counts calibration clocks, not raw reference cycles
          if (cal_tick) begin
            cal_cnt_d = cal_cnt_q + 16'h0001;
            if (cal_cnt_q == cal_last)
              cal_st_d = CAL_DONE;
          end
        end
        CAL_DONE: cal_st_d = CAL_DONE;
        default:  cal_st_d = CAL_IDLE;
      endcase
    end
  end

  // Status flops; a bit left at one after a run starts nothing new.
  // The edge history resets low to match the reset value of cal-now,
  // so leaving reset never looks like a trigger.
  always @(posedge CLK_I) begin
    if (RST_I) begin
      cal_st_q      <= CAL_IDLE;
      calnow_prev_q <= 1'b0;
      cal_cnt_q     <= 16'h0000;
      CAL_BUSY_O    <= 1'b0;
      CAL_VALID_O   <= 1'b0;
      CAL_TICK_O    <= 1'b0;
    end else begin
      cal_st_q      <= cal_st_d;
      calnow_prev_q <= calnow;
      cal_cnt_q     <= cal_cnt_d;
      CAL_BUSY_O    <= (cal_st_d == CAL_RUN);
      CAL_VALID_O   <= (cal_st_d == CAL_DONE);
      CAL_TICK_O    <= cal_tick & CAL_BUSY_O;
    end
  end

  // Counter clear per mode; registered, so async mode lags the pin by
  // one clock, the price of driving every output from a flop
  always @* begin
    case (mode)
      `PVC_SYNC_ASYNC: clear_d = sync_act;
      `PVC_SYNC_SYNC:  clear_d = sync_q;
      default:         clear_d = 1'b0;
    endcase
  end

  // Clear and path delays; delays follow the active set a clock later
  always @(posedge CLK_I) begin
    if (RST_I) begin
      sync_q      <= 1'b0;
      CNT_CLEAR_O <= 1'b0;
      REF_DLY_O   <= 3'h0;
      FB_DLY_O    <= 3'h0;
    end else begin
      sync_q      <= sync_act;
      CNT_CLEAR_O <= clear_d;
      REF_DLY_O   <= sync_dly_act_q[`PVC_RDLY_HI:`PVC_RDLY_LO];
      FB_DLY_O    <= sync_dly_act_q[`PVC_NDLY_HI:`PVC_NDLY_LO];
    end
  end
endmodule
`default_nettype wire

//--- pvc_top_chk.sv
`default_nettype none
module pvc_top_chk (
  input wire logic       CLK_I, RST_I, PREADY_O, SYNC_N_I, CNT_CLEAR_O,
  input wire logic       CAL_BUSY_O, CAL_VALID_O, CAL_TICK_O,
  input wire logic [2:0] REF_DLY_O, FB_DLY_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  tick_busy_a: assert property (CAL_TICK_O |-> $past(CAL_BUSY_O))
    else $error("tick while idle");
  tick_gap_a: assert property (CAL_TICK_O |=> !CAL_TICK_O)
    else $error("ticks too close");
  valid_idle_a: assert property (CAL_VALID_O |-> !CAL_BUSY_O)
    else $error("valid while busy");
  busy_start_a: assert property ($rose(CAL_BUSY_O) |-> $past(PREADY_O))
    else $error("start without update");
  dly_update_a: assert property ($changed({REF_DLY_O, FB_DLY_O})
    |-> $past(PREADY_O)) else $error("delay moved alone");
  clr_cause_a: assert property (CNT_CLEAR_O
    |-> !$past(SYNC_N_I) || !$past(SYNC_N_I, 2)) else $error("stray clear");
  valid_rise_a: assert property ($rose(CAL_VALID_O) |-> $past(CAL_BUSY_O))
    else $error("valid without run");
  valid_drop_a: assert property ($fell(CAL_VALID_O)
    |-> $past(PREADY_O) || $past(PREADY_O, 2)) else $error("result lost");
  cover property ($rose(CAL_VALID_O));
  cover property (CNT_CLEAR_O);
  cover property ($changed(REF_DLY_O));
endmodule
bind pvc_top pvc_top_chk pvc_top_chk_inst (.CLK_I, .RST_I, .PREADY_O,
  .SYNC_N_I, .CNT_CLEAR_O, .CAL_BUSY_O, .CAL_VALID_O, .CAL_TICK_O,
  .REF_DLY_O, .FB_DLY_O);
`default_nettype wire

//--- tb_pvc_top.sv
`include "pvc_map.vh"
`default_nettype none
module tb_pvc_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst = 1, sel = 0, en = 0, wr = 0, go = 0, e;
  logic [13:0] adr = '0;
  logic [31:0] wd = '0, q, rd;
  logic rdy, err, sn, clr, busy, vld, tk;
  logic [2:0] rdl, fdl;
  int mismatches, checks, t;
  wire logic [2:0] sig = {rdy, tk, vld};
  pvc_top #(.CAL_TICKS(16'h0004)) pvc_top_inst (.CLK_I(clk), .RST_I(rst),
    .PSEL_I(sel), .PENABLE_I(en), .PWRITE_I(wr), .PADDR_I(adr),
    .PWDATA_I(wd), .PRDATA_O(rd), .PREADY_O(rdy), .PSLVERR_O(err),
    .SYNC_N_I(sn), .CNT_CLEAR_O(clr), .REF_DLY_O(rdl), .FB_DLY_O(fdl),
    .CAL_BUSY_O(busy), .CAL_VALID_O(vld), .CAL_TICK_O(tk));
  pvc_sync_drv pvc_sync_drv_inst (.clk_i(clk), .go_i(go), .sync_n_o(sn));
  initial forever #20 clk = ~clk;
  task automatic chk(string s, logic [31:0] g, x);
    checks++;
    if (g !== x) begin
      mismatches++;
      $display("ERROR %s exp %h got %h", s, x, g);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Bounded wait for one status bit sampled high at an edge
  task automatic till(int i);
    t = 0;
    while (sig[i] !== 1'b1) begin
      @(posedge clk);
      t++;
      if (t > 999) begin
        mismatches++;
        tally_and_finish;
      end
    end
  endtask
  // Setup, access held until ready, then one idle edge
  task automatic apb(logic w, logic [13:0] a, logic [31:0] d);
    sel <= 1;
    wr <= w;
    adr <= a;
    wd <= d;
    @(posedge clk);
    en <= 1;
    till(2);
    q = rd;
    e = err;
    sel <= 0;
    en <= 0;
    @(posedge clk);
  endtask
  task automatic w8(logic [13:0] a, logic [7:0] d);
    apb(1, a, {24'h000000, d});
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    apb(0, `PVC_ADDR_SYNC_DLY, 0);
    chk("sync_dly", q, 0);
    apb(0, `PVC_ADDR_CAL_CTRL, 0);
    chk("cal_ctrl", q, `PVC_RST_CAL_CTRL);
    apb(0, 14'h0004, 0);
    chk("unmapped", {e, q[30:0]}, 32'h80000000);
    w8(`PVC_ADDR_SYNC_DLY, 8'h2b);
    chk("staged", {rdl, fdl}, 0);
    w8(`PVC_ADDR_TRANSFER, 8'h01);
    @(posedge clk);
    chk("active", {rdl, fdl}, 32'h0000002b);
    $display("registers done");
    for (int m = 0; m < 4; m++) begin
      w8(`PVC_ADDR_SYNC_DLY, {m[1:0], 6'h2b});
      w8(`PVC_ADDR_TRANSFER, 8'h01);
      go <= 1;
      t = 0;
      repeat (6) @(posedge clk) t += clr;
      // Async clear shows one clock before the synchronous one
      chk("clear", t, m == 1 ? 4 : (m == 2 ? 3 : 0));
      go <= 0;
      repeat (6) @(posedge clk);
    end
    $display("sync modes done");
    for (int c = 0; c < 4; c++) begin
      w8(`PVC_ADDR_CAL_CTRL, {5'h00, c[1:0], 1'b1});
      chk("held", busy, 0);
      w8(`PVC_ADDR_TRANSFER, 8'h01);
      till(1);
      @(posedge clk);
      till(1);
      chk("divide", t + 1, 2 << c);
      till(0);
      chk("done", busy, 0);
      apb(0, `PVC_ADDR_CAL_CTRL, 0);
      chk("readback", q, {c[1:0], 1'b1});
      w8(`PVC_ADDR_TRANSFER, 8'h01);
      repeat (4) @(posedge clk);
      chk("retrigger", busy, 0);
      chk("kept", vld, 1);
      w8(`PVC_ADDR_CAL_CTRL, {5'h00, c[1:0], 1'b0});
      w8(`PVC_ADDR_TRANSFER, 8'h01);
      repeat (2) @(posedge clk);
      chk("discard", vld, 0);
    end
    $display("calibration done");
    tally_and_finish;
  end
endmodule
`default_nettype wire
